//--- inc/emr_pkg.sv
// Constants for the Ethernet MAC control register bank
package emr_pkg;
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int BW = 11;
  // Register byte addresses
  localparam logic [15:0] OFS_PAUSE_LO  = 16'hFC58;
  localparam logic [15:0] OFS_PAUSE_HI  = 16'hFC5C;
  localparam logic [15:0] OFS_FULL      = 16'hFC60;
  localparam logic [15:0] OFS_MISC      = 16'hFC68;
  localparam logic [15:0] OFS_SA_LO     = 16'hFC6C;
  localparam logic [15:0] OFS_SA_MID    = 16'hFC70;
  localparam logic [15:0] OFS_SA_HI     = 16'hFC74;
  localparam logic [15:0] OFS_MAX_TRANSMIT_LENGTH     = 16'hFC7C;
  localparam logic [15:0] OFS_FILTER    = 16'hFC80;
  localparam logic [15:0] OFS_MGMT_CTL  = 16'hFC84;
  localparam logic [15:0] OFS_MGMT_DATA = 16'hFC88;
  localparam logic [15:0] OFS_PINS      = 16'hFC8C;
  localparam logic [15:0] OFS_RXIND     = 16'hFC90;
  localparam logic [15:0] OFS_TRANSMIT_FAIL_STATUS      = 16'hFC94;
  // Reset values
  localparam logic [10:0] RST_PAUSE_LO = 11'h300;
  localparam logic [10:0] RST_PAUSE_HI = 11'h600;
  localparam logic [10:0] RST_FULL     = 11'h100;
  localparam logic [5:0]  RST_MISC     = 6'h13;
  localparam logic [10:0] RST_MAX_TRANSMIT_LENGTH    = 11'h5FC;
  localparam logic [5:0]  RST_FILTER   = 6'h04;
  localparam logic [1:0]  RST_PIN_DIR  = 2'h3;
  // Field positions
  localparam int MISC_MAC_RST  = 0;
  localparam int MISC_PHY_RST  = 1;
  localparam int MISC_WAKE_PAT = 4;
  localparam int MISC_WAKE_ON_LINK_UP = 5;
  localparam int FLT_ANY       = 0;
  localparam int FLT_ALL_MC    = 1;
  localparam int FLT_UNI       = 2;
  localparam int FLT_BCAST     = 3;
  localparam int FLT_HASH      = 4;
  localparam int FLT_CRC_OK    = 5;
  localparam int MG_WR_GO      = 15;
  localparam int MG_RD_GO      = 14;
  localparam int MG_IDX_LSB    = 8;
  localparam int MG_ADDR_LSB   = 0;
  localparam int PIN_LVL_LSB   = 8;
  localparam int HASH_MSB      = 31;
  localparam int HASH_LSB      = 27;
  localparam logic [4:0]  INT_PHY_ADDR = 5'h10;
  localparam logic [15:0] NO_PHY_DATA  = 16'hFFFF;
  localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
  typedef enum logic [1:0] {
    EMR_MG_IDLE = 2'b00,
    EMR_MG_REQ  = 2'b01,
    EMR_MG_DONE = 2'b11
  } emr_mg_state_t;
endpackage : emr_pkg

//--- inc/emr_mgmt_if.sv
// Link between the register bank and the PHY management engine
`timescale 1ns/1ps
interface emr_mgmt_if;
  logic        wr_go;
  logic        rd_go;
  logic [4:0]  phy_addr;
  logic [4:0]  reg_idx;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctl (output wr_go, rd_go, phy_addr, reg_idx, wdata, input done, rdata);
  modport eng (input wr_go, rd_go, phy_addr, reg_idx, wdata, output done, rdata);
endinterface : emr_mgmt_if

//--- hw/emr_mgmt.sv
// PHY management access engine
`timescale 1ns/1ps
module emr_mgmt (
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     ce_in,
  emr_mgmt_if.eng       mg,
  input  wire logic     phy_ack_in,
  input  wire logic [15:0] phy_rdata_in,
  output logic          phy_req_out,
  output logic          phy_we_out,
  output logic [4:0]    phy_idx_out,
  output logic [15:0]   phy_wdata_out
);
  import emr_pkg::*;
  emr_mg_state_t state;
  logic [15:0]   rdata;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= EMR_MG_IDLE;
    end else if (ce_in) begin
      unique case (state)
        EMR_MG_IDLE: begin
          if (mg.wr_go || mg.rd_go) begin
            // Only the internal PHY answers; others finish at once
            state <= (mg.phy_addr == INT_PHY_ADDR) ? EMR_MG_REQ : EMR_MG_DONE;
          end
        end
        EMR_MG_REQ: begin
          if (phy_ack_in) begin
            state <= EMR_MG_DONE;
          end
        end
        EMR_MG_DONE: begin
          state <= EMR_MG_IDLE;
        end
        default: begin
          state <= EMR_MG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata <= 16'h0000;
    end else if (ce_in) begin
      if (state == EMR_MG_IDLE && (mg.wr_go || mg.rd_go) && mg.phy_addr != INT_PHY_ADDR) begin
        rdata <= NO_PHY_DATA;
      end else if (state == EMR_MG_REQ && phy_ack_in) begin
        rdata <= phy_rdata_in;
      end
    end
  end

  assign mg.done       = (state == EMR_MG_DONE);
  assign mg.rdata      = rdata;
  assign phy_req_out   = (state == EMR_MG_REQ);
  assign phy_we_out    = mg.wr_go;
  assign phy_idx_out   = mg.reg_idx;
  assign phy_wdata_out = mg.wdata;

  AST_MG_REQ_ONLY_INT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phy_req_out |-> mg.phy_addr == INT_PHY_ADDR)
    else $error("request to a non-internal PHY address");
endmodule : emr_mgmt

//--- hw/emr_regs.sv
// Ethernet MAC control and status register bank
`timescale 1ns/1ps
module emr_regs (
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   ce_in,
  input  wire logic                   host_cs_in,
  input  wire logic                   host_wr_in,
  input  wire logic                   host_rd_in,
  input  wire logic [emr_pkg::AW-1:0] host_addr_in,
  input  wire logic [emr_pkg::DW-1:0] host_wdata_in,
  output logic      [emr_pkg::DW-1:0] host_rdata_out,
  input  wire logic                   rx_pause_enable_in,
  input  wire logic                   rx_buffer_monitor_enable_in,
  input  wire logic [emr_pkg::BW-1:0] rx_free_space_in,
  output logic                        pause_request_out,
  output logic                        rx_full_out,
  input  wire logic                   link_up_event_in,
  input  wire logic                   pattern_frame_in,
  input  wire logic                   wake_polarity_in,
  output logic                        wake_out,
  output logic                        mac_soft_reset_n_out,
  output logic                        phy_soft_reset_n_out,
  input  wire logic                   eeprom_present_in,
  input  wire logic                   eeprom_addr_valid_in,
  input  wire logic [47:0]            eeprom_addr_in,
  output logic      [47:0]            station_addr_out,
  input  wire logic [emr_pkg::BW-1:0] tx_frame_len_in,
  output logic      [emr_pkg::BW-1:0] tx_size_limit_out,
  output logic                        tx_len_allowed_out,
  input  wire logic                   frame_valid_in,
  input  wire logic [47:0]            frame_da_in,
  input  wire logic                   frame_crc_ok_in,
  input  wire logic [63:0]            hash_table_in,
  output logic                        frame_accept_out,
  output logic                        frame_drop_out,
  input  wire logic                   phy_ack_in,
  input  wire logic [15:0]            phy_rdata_in,
  output logic                        phy_req_out,
  output logic                        phy_we_out,
  output logic      [4:0]             phy_idx_out,
  output logic      [15:0]            phy_wdata_out,
  input  wire logic [1:0]             gpio_in,
  output logic      [1:0]             gpio_out,
  output logic      [1:0]             gpio_oe_out,
  output logic                        host_rx_read_active_out,
  input  wire logic [3:0]             tx_fail_in
);
  import emr_pkg::*;

  logic [BW-1:0] pause_on_bound;
  logic [BW-1:0] pause_off_bound;
  logic [BW-1:0] buffer_full_bound;
  logic [5:0]    misc;
  logic [15:0]   station_addr_lo;
  logic [15:0]   station_addr_mid;
  logic [15:0]   station_addr_hi;
  logic [BW-1:0] tx_size_limit;
  logic [5:0]    filter;
  logic          mgmt_write_go;
  logic          mgmt_read_go;
  logic [4:0]    mgmt_reg_index;
  logic [4:0]    mgmt_phy_addr;
  logic [15:0]   mgmt_data_word;
  logic [1:0]    pin_is_input;
  logic [1:0]    pin_drive;
  logic [1:0]    pin_sample;
  logic          host_rx_read_active;
  logic [3:0]    tx_failed;
  logic          pause_active;
  logic [DW-1:0] next_rdata;
  logic          wr_en;
  logic          rd_en;
  logic          mg_busy;
  logic          fc_on;
  logic          is_mcast;
  logic          is_bcast;
  logic          da_match;
  logic          hash_hit;
  logic          next_accept;
  logic [31:0]   da_crc;
  logic [4:0]    hash_idx;

  emr_mgmt_if mg ();

  assign wr_en   = host_cs_in && host_wr_in;
  assign rd_en   = host_cs_in && host_rd_in;
  assign mg_busy = mgmt_write_go || mgmt_read_go;

  // Threshold registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pause_on_bound    <= RST_PAUSE_LO;
      pause_off_bound   <= RST_PAUSE_HI;
      buffer_full_bound <= RST_FULL;
      tx_size_limit     <= RST_MAX_TRANSMIT_LENGTH;
    end else if (ce_in && wr_en) begin
      unique case (host_addr_in)
        OFS_PAUSE_LO: pause_on_bound <= host_wdata_in[BW-1:0];
        OFS_PAUSE_HI: pause_off_bound <= host_wdata_in[BW-1:0];
        OFS_FULL:     buffer_full_bound <= host_wdata_in[BW-1:0];
        OFS_MAX_TRANSMIT_LENGTH:    tx_size_limit <= host_wdata_in[BW-1:0];
        default: ;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      misc                <= RST_MISC;
      filter              <= RST_FILTER;
      pin_is_input        <= RST_PIN_DIR;
      pin_drive           <= 2'h0;
      host_rx_read_active <= 1'b0;
    end else if (ce_in && wr_en) begin
      unique case (host_addr_in)
        OFS_MISC:   misc <= {host_wdata_in[5:4], 2'b00, host_wdata_in[1:0]};
        OFS_FILTER: filter <= host_wdata_in[5:0];
        OFS_PINS: begin
          pin_is_input <= host_wdata_in[1:0];
          pin_drive    <= host_wdata_in[PIN_LVL_LSB+1:PIN_LVL_LSB];
        end
        OFS_RXIND:  host_rx_read_active <= host_wdata_in[0];
        default: ;
      endcase
    end
  end

  // Station address; a load from the memory overrides a host write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      station_addr_lo  <= 16'h0000;
      station_addr_mid <= 16'h0000;
      station_addr_hi  <= 16'h0000;
    end else if (ce_in) begin
      if (eeprom_present_in && eeprom_addr_valid_in) begin
        {station_addr_hi, station_addr_mid, station_addr_lo} <= eeprom_addr_in;
      end else if (wr_en) begin
        unique case (host_addr_in)
          OFS_SA_LO:  station_addr_lo <= host_wdata_in[15:0];
          OFS_SA_MID: station_addr_mid <= host_wdata_in[15:0];
          OFS_SA_HI:  station_addr_hi <= host_wdata_in[15:0];
          default: ;
        endcase
      end
    end
  end

  assign station_addr_out = {station_addr_hi, station_addr_mid, station_addr_lo};

  // Management control; writes are ignored while an access runs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mgmt_write_go  <= 1'b0;
      mgmt_read_go   <= 1'b0;
      mgmt_reg_index <= 5'h00;
      mgmt_phy_addr  <= 5'h00;
    end else if (ce_in) begin
      if (mg.done) begin
        mgmt_write_go <= 1'b0;
        mgmt_read_go  <= 1'b0;
      end else if (wr_en && host_addr_in == OFS_MGMT_CTL && !mg_busy) begin
        mgmt_write_go  <= host_wdata_in[MG_WR_GO];
        mgmt_read_go   <= host_wdata_in[MG_RD_GO] && !host_wdata_in[MG_WR_GO];
        mgmt_reg_index <= host_wdata_in[MG_IDX_LSB+4:MG_IDX_LSB];
        mgmt_phy_addr  <= host_wdata_in[MG_ADDR_LSB+4:MG_ADDR_LSB];
      end
    end
  end

  // Data port; read result lands as the go bit clears
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mgmt_data_word <= 16'h0000;
    end else if (ce_in) begin
      if (mg.done && mgmt_read_go) begin
        mgmt_data_word <= mg.rdata;
      end else if (wr_en && host_addr_in == OFS_MGMT_DATA && !mg_busy) begin
        mgmt_data_word <= host_wdata_in[15:0];
      end
    end
  end

  assign mg.wr_go    = mgmt_write_go;
  assign mg.rd_go    = mgmt_read_go;
  assign mg.phy_addr = mgmt_phy_addr;
  assign mg.reg_idx  = mgmt_reg_index;
  assign mg.wdata    = mgmt_data_word;

  emr_mgmt u_mgmt (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .mg            (mg),
    .phy_ack_in    (phy_ack_in),
    .phy_rdata_in  (phy_rdata_in),
    .phy_req_out   (phy_req_out),
    .phy_we_out    (phy_we_out),
    .phy_idx_out   (phy_idx_out),
    .phy_wdata_out (phy_wdata_out)
  );

  // Transmit fail flags; a new failure beats the read clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_failed <= 4'h0;
    end else if (ce_in) begin
      if (rd_en && host_addr_in == OFS_TRANSMIT_FAIL_STATUS) begin
        tx_failed <= tx_fail_in;
      end else begin
        tx_failed <= tx_failed | tx_fail_in;
      end
    end
  end

  // Pin levels are taken as synchronous, one register stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_sample <= 2'h0;
    end else if (ce_in) begin
      pin_sample <= gpio_in;
    end
  end

  assign gpio_oe_out = ~pin_is_input;
  assign gpio_out    = pin_drive;

  // Read mux; reserved bits read zero
  always_comb begin
    next_rdata = '0;
    unique case (host_addr_in)
      OFS_PAUSE_LO:  next_rdata[BW-1:0] = pause_on_bound;
      OFS_PAUSE_HI:  next_rdata[BW-1:0] = pause_off_bound;
      OFS_FULL:      next_rdata[BW-1:0] = buffer_full_bound;
      OFS_MISC:      next_rdata[5:0] = misc;
      OFS_SA_LO:     next_rdata[15:0] = station_addr_lo;
      OFS_SA_MID:    next_rdata[15:0] = station_addr_mid;
      OFS_SA_HI:     next_rdata[15:0] = station_addr_hi;
      OFS_MAX_TRANSMIT_LENGTH:     next_rdata[BW-1:0] = tx_size_limit;
      OFS_FILTER:    next_rdata[5:0] = filter;
      OFS_MGMT_CTL:  next_rdata[15:0] = {mgmt_write_go, mgmt_read_go, 1'b0, mgmt_reg_index,
                                         3'b000, mgmt_phy_addr};
      OFS_MGMT_DATA: next_rdata[15:0] = mgmt_data_word;
      OFS_PINS: begin
        next_rdata[1:0] = pin_is_input;
        // Input mode shows the pin, output mode the driven level
        next_rdata[PIN_LVL_LSB+1:PIN_LVL_LSB] = (pin_is_input & pin_sample) |
                                                (~pin_is_input & pin_drive);
      end
      OFS_RXIND:     next_rdata[0] = host_rx_read_active;
      OFS_TRANSMIT_FAIL_STATUS:      next_rdata[3:0] = tx_failed;
      default:       next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      host_rdata_out <= '0;
    end else if (ce_in && rd_en) begin
      host_rdata_out <= next_rdata;
    end
  end

  // Pause generation with hysteresis
  assign fc_on = rx_pause_enable_in && rx_buffer_monitor_enable_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pause_active <= 1'b0;
    end else if (ce_in) begin
      if (!fc_on) begin
        pause_active <= 1'b0;
      end else if (rx_free_space_in < pause_on_bound) begin
        pause_active <= 1'b1;
      end else if (rx_free_space_in > pause_off_bound) begin
        pause_active <= 1'b0;
      end
    end
  end

  assign pause_request_out = pause_active;
  assign rx_full_out       = rx_free_space_in < buffer_full_bound;

  // Wake pin; idle level is the inverse of the polarity select
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_out <= 1'b0;
    end else if (ce_in) begin
      wake_out <= wake_polarity_in ^ ~((misc[MISC_WAKE_ON_LINK_UP] && link_up_event_in) ||
                                      (misc[MISC_WAKE_PAT] && pattern_frame_in));
    end
  end

  assign mac_soft_reset_n_out = misc[MISC_MAC_RST];
  assign phy_soft_reset_n_out = misc[MISC_PHY_RST];
  assign tx_size_limit_out    = tx_size_limit;
  assign tx_len_allowed_out   = tx_frame_len_in <= tx_size_limit;
  assign host_rx_read_active_out = host_rx_read_active;

  // CRC32 over the address, first byte in bits 47:40, each byte LSB first
  function automatic logic [31:0] emr_da_crc(input logic [47:0] da);
    logic [31:0] c;
    logic        fb;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[31] ^ da[47 - 8 * i - 7 + j];
        c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction : emr_da_crc

  assign da_crc   = emr_da_crc(frame_da_in);
  assign hash_idx = da_crc[HASH_MSB:HASH_LSB];
  assign hash_hit = hash_table_in[{1'b0, hash_idx}];
  assign is_mcast = frame_da_in[40];
  assign is_bcast = &frame_da_in;
  assign da_match = frame_da_in == station_addr_out;

  always_comb begin
    next_accept = filter[FLT_ANY];
    if (frame_crc_ok_in && filter[FLT_CRC_OK]) next_accept = 1'b1;
    if (filter[FLT_HASH] && is_mcast && hash_hit) next_accept = 1'b1;
    if (filter[FLT_BCAST] && is_bcast) next_accept = 1'b1;
    if (filter[FLT_UNI] && da_match && frame_crc_ok_in) next_accept = 1'b1;
    if (filter[FLT_ALL_MC] && is_mcast && frame_crc_ok_in) next_accept = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_accept_out <= 1'b0;
      frame_drop_out   <= 1'b0;
    end else if (ce_in) begin
      frame_accept_out <= frame_valid_in && next_accept;
      frame_drop_out   <= frame_valid_in && !next_accept;
    end
  end

  AST_PAUSE_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && fc_on && rx_free_space_in < pause_on_bound |=> pause_request_out)
    else $error("pause not raised below low bound");
  AST_PAUSE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && fc_on && pause_request_out && rx_free_space_in <= pause_off_bound
    |=> pause_request_out)
    else $error("pause dropped before high bound");
  AST_PAUSE_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !fc_on |=> !pause_request_out)
    else $error("pause active with flow control off");
  AST_FULL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rx_full_out == (rx_free_space_in < buffer_full_bound))
    else $error("full flag wrong");
  AST_WAKE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && misc[MISC_WAKE_ON_LINK_UP] && link_up_event_in |=> wake_out == $past(wake_polarity_in))
    else $error("no wake on link up");
  AST_GO_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && mg.done |=> !mgmt_write_go && !mgmt_read_go)
    else $error("go bit not cleared after access");
  AST_RD_DATA: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && mg.done && mgmt_read_go |=> mgmt_data_word == $past(mg.rdata))
    else $error("read result not loaded");
  AST_TRANSMIT_FAIL_STATUS_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && tx_fail_in[0] ##1 ce_in && !(rd_en && host_addr_in == OFS_TRANSMIT_FAIL_STATUS)[*2]
    |=> tx_failed[0])
    else $error("fail flag lost");
  AST_FILTER_ANY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && frame_valid_in && filter[FLT_ANY] |=> frame_accept_out && !frame_drop_out)
    else $error("frame dropped in accept-all mode");
  AST_PIN_DIR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    gpio_oe_out == ~pin_is_input)
    else $error("pin enable disagrees with direction");
endmodule : emr_regs

//--- verification/emr_phy_model.sv
// Behavioural PHY on the far side of the management engine
`timescale 1ns/1ps
module emr_phy_model #(
  parameter int DELAY = 3
) (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [4:0]  idx_in,
  input  wire logic [15:0] wdata_in,
  output logic             ack_out,
  output logic [15:0]      rdata_out
);
  logic [15:0] regs [32];
  int          wait_cnt;
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 16'hA500 | 16'(i);
    ack_out = 1'b0;
    rdata_out = 16'h0000;
    wait_cnt = 0;
  end
  // Data toggles outside the ack cycle so stale reads cannot look right
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (wait_cnt == DELAY) begin
        ack_out <= 1'b1;
        wait_cnt <= 0;
        rdata_out <= regs[idx_in];
        if (we_in) regs[idx_in] <= wdata_in;
      end else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : emr_phy_model

//--- verification/testbench.sv
// Self-checking bench for the MAC control register bank
`timescale 1ns/1ps
module testbench;
  import emr_pkg::*;
  logic clk_in, rst_n_in, host_cs_in, host_wr_in, host_rd_in, rx_pause_enable_in;
  logic rx_buffer_monitor_enable_in, link_up_event_in, pattern_frame_in, wake_polarity_in;
  logic frame_valid_in, frame_crc_ok_in, phy_ack_in, pause_request_out, rx_full_out, wake_out;
  logic mac_soft_reset_n_out, phy_soft_reset_n_out, tx_len_allowed_out, frame_accept_out;
  logic frame_drop_out, phy_req_out, phy_we_out, host_rx_read_active_out;
  logic [15:0] host_addr_in, phy_rdata_in, phy_wdata_out;
  logic [31:0] host_wdata_in, host_rdata_out, d;
  logic [10:0] rx_free_space_in, tx_frame_len_in, tx_size_limit_out;
  logic [47:0] frame_da_in, station_addr_out, eeprom_addr_in;
  logic [63:0] hash_table_in;
  logic        ce_in, eeprom_present_in, eeprom_addr_valid_in;
  logic [4:0]  phy_idx_out;
  logic [1:0]  gpio_in, gpio_out, gpio_oe_out;
  logic [3:0]  tx_fail_in;
  int          mismatches, n_tests;

  emr_regs i_emr_regs (.clk_in, .rst_n_in, .ce_in, .host_cs_in, .host_wr_in, .host_rd_in,
    .host_addr_in, .host_wdata_in, .host_rdata_out, .rx_pause_enable_in,
    .rx_buffer_monitor_enable_in, .rx_free_space_in, .pause_request_out, .rx_full_out,
    .link_up_event_in, .pattern_frame_in, .wake_polarity_in, .wake_out, .mac_soft_reset_n_out,
    .phy_soft_reset_n_out, .eeprom_present_in, .eeprom_addr_valid_in,
    .eeprom_addr_in, .station_addr_out, .tx_frame_len_in, .tx_size_limit_out,
    .tx_len_allowed_out, .frame_valid_in, .frame_da_in, .frame_crc_ok_in,
    .hash_table_in, .frame_accept_out, .frame_drop_out, .phy_ack_in,
    .phy_rdata_in, .phy_req_out, .phy_we_out, .phy_idx_out, .phy_wdata_out, .gpio_in,
    .gpio_out, .gpio_oe_out, .host_rx_read_active_out, .tx_fail_in);
  emr_phy_model i_emr_phy_model (.clk_in, .req_in(phy_req_out), .we_in(phy_we_out),
    .idx_in(phy_idx_out), .wdata_in(phy_wdata_out), .ack_out(phy_ack_in),
    .rdata_out(phy_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic complete_run;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(negedge clk_in);
    {host_cs_in, host_wr_in, host_addr_in, host_wdata_in} = {2'b11, a, v};
    @(negedge clk_in);
    {host_cs_in, host_wr_in} = 2'b00;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(negedge clk_in);
    {host_cs_in, host_rd_in, host_addr_in} = {2'b11, a};
    @(negedge clk_in);
    {host_cs_in, host_rd_in} = 2'b00;
    v = host_rdata_out;
  endtask : rd

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    rd(a, d);
    chk(d, e);
  endtask : rdchk

  task automatic frm(input logic [47:0] a, input logic c, input logic e);
    @(negedge clk_in);
    {frame_valid_in, frame_da_in, frame_crc_ok_in} = {1'b1, a, c};
    @(negedge clk_in);
    frame_valid_in = 1'b0;
    chk({frame_accept_out, frame_drop_out}, {e, !e});
  endtask : frm

  // Polling keeps the host order: no new request while a go bit stands
  task automatic mgmt_idle;
    repeat (40) begin
      rd(OFS_MGMT_CTL, d);
      if (d[15:14] === 2'b00) return;
    end
    mismatches++;
    complete_run();
  endtask : mgmt_idle

  task automatic t_reset_values;
    rdchk(OFS_PAUSE_LO, 32'h300);
    rdchk(OFS_PAUSE_HI, 32'h600);
    rdchk(OFS_FULL, 32'h100);
    rdchk(OFS_MISC, 32'h13);
    rdchk(OFS_MAX_TRANSMIT_LENGTH, 32'h5FC);
    rdchk(OFS_FILTER, 32'h4);
    rdchk(OFS_PINS, 32'h3);
    rdchk(OFS_TRANSMIT_FAIL_STATUS, 32'h0);
  endtask : t_reset_values

  task automatic t_soft_reset;
    wr(OFS_MISC, 32'h12);
    chk(mac_soft_reset_n_out, 1'b0);
    wr(OFS_MISC, 32'h11);
    chk({phy_soft_reset_n_out, mac_soft_reset_n_out}, 2'b01);
    wr(OFS_MISC, 32'h23);
  endtask : t_soft_reset

  task automatic t_levels;
    {rx_pause_enable_in, rx_buffer_monitor_enable_in, rx_free_space_in} = {2'b11, 11'h2FF};
    @(negedge clk_in);
    chk({pause_request_out, rx_full_out}, 2'b10);
    rx_free_space_in = 11'h600;
    @(negedge clk_in);
    chk(pause_request_out, 1'b1);
    rx_free_space_in = 11'h601;
    @(negedge clk_in);
    chk(pause_request_out, 1'b0);
    {rx_buffer_monitor_enable_in, rx_free_space_in} = {1'b0, 11'h0FF};
    @(negedge clk_in);
    chk({pause_request_out, rx_full_out}, 2'b01);
    tx_frame_len_in = 11'h5FD;
    #1 chk(tx_len_allowed_out, 1'b0);
    chk(tx_size_limit_out, 11'h5FC);
    {link_up_event_in, wake_polarity_in} = 2'b11;
    @(negedge clk_in);
    link_up_event_in = 1'b0;
    chk(wake_out, 1'b1);
  endtask : t_levels

  task automatic t_filter;
    wr(OFS_SA_LO, 32'h5566);
    wr(OFS_SA_MID, 32'h3344);
    wr(OFS_SA_HI, 32'h1122);
    chk(station_addr_out, 48'h1122_3344_5566);
    frm(48'h1122_3344_5566, 1'b1, 1'b1);
    frm(48'h1122_3344_5566, 1'b0, 1'b0);
    frm(48'hFFFF_FFFF_FFFF, 1'b1, 1'b0);
    wr(OFS_FILTER, 32'h08);
    frm(48'hFFFF_FFFF_FFFF, 1'b1, 1'b1);
    wr(OFS_FILTER, 32'h02);
    frm(48'h0100_5E00_0001, 1'b1, 1'b1);
    wr(OFS_FILTER, 32'h10);
    frm(48'h0100_5E00_0001, 1'b1, 1'b1);
    hash_table_in = '0;
    frm(48'h0100_5E00_0001, 1'b1, 1'b0);
    wr(OFS_FILTER, 32'h20);
    frm(48'h0200_0000_0009, 1'b1, 1'b1);
    wr(OFS_FILTER, 32'h01);
    frm(48'h0200_0000_0009, 1'b0, 1'b1);
    {eeprom_present_in, eeprom_addr_valid_in, eeprom_addr_in} = {2'b11, 48'h0A0B_0C0D_0E0F};
    @(negedge clk_in);
    eeprom_addr_valid_in = 1'b0;
    chk(station_addr_out, 48'h0A0B_0C0D_0E0F);
  endtask : t_filter

  task automatic t_misc;
    wr(16'hFC64, 32'hFFFF_FFFF);
    rdchk(16'hFC64, 32'h0);
    wr(OFS_MGMT_DATA, 32'h1234);
    wr(OFS_MGMT_CTL, 32'h8310);
    mgmt_idle();
    // Clear the port so the read result cannot be the leftover write data
    wr(OFS_MGMT_DATA, 32'h0);
    wr(OFS_MGMT_CTL, 32'h4310);
    mgmt_idle();
    rdchk(OFS_MGMT_DATA, 32'h1234);
    wr(OFS_MGMT_CTL, 32'h4305);
    mgmt_idle();
    rdchk(OFS_MGMT_DATA, 32'hFFFF);
    {gpio_in, tx_fail_in} = {2'b10, 4'h5};
    @(negedge clk_in);
    tx_fail_in = 4'h0;
    rdchk(OFS_TRANSMIT_FAIL_STATUS, 32'h5);
    rdchk(OFS_TRANSMIT_FAIL_STATUS, 32'h0);
    wr(OFS_PINS, 32'h0002);
    wr(OFS_PINS, 32'h0102);
    rd(OFS_PINS, d);
    chk({gpio_oe_out, gpio_out[0], d[9]}, 4'b0111);
    wr(OFS_RXIND, 32'h1);
    chk(host_rx_read_active_out, 1'b1);
    ce_in = 1'b0;
    wr(OFS_RXIND, 32'h0);
    chk(host_rx_read_active_out, 1'b1);
    ce_in = 1'b1;
    wr(OFS_RXIND, 32'h0);
    chk(host_rx_read_active_out, 1'b0);
  endtask : t_misc

  initial begin
    {rst_n_in, host_cs_in, host_wr_in, host_rd_in, host_addr_in, host_wdata_in} = '0;
    {rx_pause_enable_in, rx_buffer_monitor_enable_in, rx_free_space_in} = '0;
    {link_up_event_in, pattern_frame_in, wake_polarity_in, frame_valid_in} = '0;
    {frame_da_in, frame_crc_ok_in, gpio_in, tx_fail_in, tx_frame_len_in} = '0;
    {ce_in, hash_table_in} = {1'b1, 64'hFFFF_FFFF};
    {eeprom_present_in, eeprom_addr_valid_in, eeprom_addr_in} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset_values();
    t_soft_reset();
    t_levels();
    t_filter();
    t_misc();
    complete_run();
  end
endmodule : testbench
